// ===== hw/iodr_params.svh
// constants for the imu output data register block
// assumes: included by bare name before iodr_pkg
`ifndef IODR_PARAMS_SVH
`define IODR_PARAMS_SVH
`define IODR_WORD_W        16
`define IODR_SAMPLE_W      32
`define IODR_SUM_W         50
`define IODR_TICK_W        16
`define IODR_ADDR_W        7
`define IODR_CLK_PERIOD_PS 4000
`define IODR_TS_LSB_PS     49020000
`define IODR_SYNC_SCALED   3'b010
`define IODR_WORD_ZERO     16'h0000
`define IODR_WORD_ONE      16'h0001
`define IODR_DANG_SHIFT    16
`define IODR_DANG_MUL_360  16'h4000
`define IODR_DANG_MUL_720  16'h2000
`define IODR_DANG_MUL_2160 16'h0aab
`define IODR_VAR_360       2'h0
`define IODR_VAR_720       2'h1
`define IODR_VAR_2160      2'h2
`define IODR_OFF_ACCX_LO   7'h10
`define IODR_OFF_ACCX_HI   7'h12
`define IODR_OFF_ACCY_LO   7'h14
`define IODR_OFF_ACCY_HI   7'h16
`define IODR_OFF_ACCZ_LO   7'h18
`define IODR_OFF_ACCZ_HI   7'h1a
`define IODR_OFF_TEMP      7'h1c
`define IODR_OFF_STAMP     7'h1e
`define IODR_OFF_COUNT     7'h22
`define IODR_OFF_DANGX_LO  7'h24
`define IODR_OFF_DANGX_HI  7'h26
`define IODR_OFF_DANGY_LO  7'h28
`define IODR_OFF_DANGY_HI  7'h2a
`define IODR_OFF_DANGZ_LO  7'h2c
`define IODR_OFF_DANGZ_HI  7'h2e
`endif

// ===== hw/iodr_pkg.sv
// state types for the imu output data register block
// assumes: iodr_params.svh is available on the include path
`include "iodr_params.svh"
package iodr_pkg;
    typedef logic [`IODR_WORD_W-1:0]   iodr_word_t;
    typedef logic [`IODR_SAMPLE_W-1:0] iodr_sample_t;

    typedef struct packed {
        logic                    sync_meta;
        logic                    sync_sync;
        logic                    sync_prev;
        logic [`IODR_TICK_W-1:0] tick;
        iodr_word_t              ts_run;
        iodr_word_t              dec_cnt;
        iodr_sample_t [2:0]      accel;
        iodr_word_t              temp;
        iodr_word_t              stamp;
        iodr_word_t              count;
        iodr_word_t              rd_data;
        logic                    rd_ack;
        logic                    ready;
    } iodr_top_s;

    typedef struct packed {
        iodr_sample_t                   prev;
        logic signed [`IODR_SUM_W-1:0] sum;
        iodr_sample_t                   dang;
    } iodr_integ_s;
endpackage

// ===== hw/iodr_integ.sv
// one axis of trapezoidal delta angle integration
// assumes: sample and last come from the same clock domain
module iodr_integ
    import iodr_pkg::*;
(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    // sample flow
    input  wire logic         sample,
    input  wire logic         last,
    input  wire logic         clear,
    input  wire iodr_sample_t rate,
    input  wire iodr_word_t   scale,
    // result
    output iodr_sample_t      dang
);
    iodr_integ_s                    s_q;
    iodr_integ_s                    s_d;
    logic signed [32:0]             term;
    logic signed [`IODR_SUM_W-1:0]  total;
    logic signed [`IODR_SUM_W+16:0] prod;

    always_comb
    begin
        s_d   = s_q;
        term  = $signed({rate[31], rate}) + $signed({s_q.prev[31], s_q.prev}); // R9
        total = s_q.sum + $signed({{(`IODR_SUM_W-33){term[32]}}, term});
        prod  = total * $signed({1'b0, scale}); // R9 R11
        if (clear)
        begin
            s_d.prev = '0;
            s_d.sum  = '0;
        end
        else if (sample)
        begin
            s_d.prev = rate;
            if (last)
            begin
                // dec+1 terms per output period
                s_d.sum  = '0; // R10
                s_d.dang = prod[`IODR_DANG_SHIFT +: `IODR_SAMPLE_W]; // R13
            end
            else
            begin
                s_d.sum = total; // R10
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign dang = s_q.dang;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_sum_restart;
        sample && last && !clear |=> s_q.sum == 0;
    endproperty
    a_sum_restart: assert property (p_sum_restart) else $error("sum not restarted after update"); // R10

    property p_dang_load;
        sample && last && !clear |=> dang == $past(prod[`IODR_DANG_SHIFT +: `IODR_SAMPLE_W]);
    endproperty
    a_dang_load: assert property (p_dang_load) else $error("delta angle not loaded"); // R9

    property p_dang_hold;
        !(sample && last) |=> $stable(dang);
    endproperty
    a_dang_hold: assert property (p_dang_hold) else $error("delta angle moved between updates"); // R16
endmodule

// ===== hw/iodr_top.sv
// output data registers of the inertial module: accel, temp, stamp,
// update counter and delta angles, read through a word read port
// assumes: sensor words and sample_strobe come from ref_clk logic;
// sync_pin is asynchronous
//
// What this block does
// R1 - accel high word is 16-bit two's complement, 1.25 mg per count
// R2 - accel low word adds 16 resolution bits, forming 32-bit sample
// R3 - temperature word two's complement, 0.1 degC per count, 0 at 0 degC
// R4 - time stamp counts 49.02 us units since last sync pulse
// R5 - time stamp meaningful only in scaled sync mode, code 010
// R6 - each update loads stamp with time of its final sample
// R7 - update counter starts at zero after power-on or reset command
// R8 - counter increments per update and wraps from ffff to zero
// R9 - delta angle is trapezoid sum of rate pairs over twice sample rate
// R10 - summation spans decimation setting plus one pre-decimation samples
// R11 - internal sample clock nominally 2000 sps sets integration scale
// R12 - host may rescale delta angle by measured data-ready rate
// R13 - each delta angle is two words forming 32-bit two's complement
// R14 - delta angle range 360, 720 or 2160 degrees by variant
// R15 - delta angle high word count is range over 2 to 15th
// R16 - high and low words of one value load together
module iodr_top
    import iodr_pkg::*;
#(
    parameter int TS_CYCLES = `IODR_TS_LSB_PS / `IODR_CLK_PERIOD_PS
)
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    // sensor samples, pre-decimation
    input  wire logic                    sample_strobe,
    input  wire iodr_sample_t [2:0]      accel_in,
    input  wire iodr_sample_t [2:0]      rate_in,
    input  wire iodr_word_t              temp_in,
    // configuration
    input  wire logic [2:0]              sync_mode,
    input  wire iodr_word_t              decimation_setting,
    input  wire logic [1:0]              variant,
    input  wire logic                    reset_cmd,
    // external sync pin
    input  wire logic                    sync_pin,
    // register read port
    input  wire logic                    rd_req,
    input  wire logic [`IODR_ADDR_W-1:0] rd_addr,
    output iodr_word_t                   rd_data,
    output logic                         rd_ack,
    // update marker
    output logic                         data_ready_output
);
    iodr_top_s          s_q;
    iodr_top_s          s_d;
    iodr_sample_t [2:0] dang;
    iodr_word_t         scale;
    iodr_word_t         mux;
    logic               sync_edge;
    logic               scaled;
    logic               update;

    // variant sets the count weight of the delta angle output
    always_comb
    begin
        case (variant)
            `IODR_VAR_360:  scale = `IODR_DANG_MUL_360; // R14
            `IODR_VAR_720:  scale = `IODR_DANG_MUL_720; // R14
            `IODR_VAR_2160: scale = `IODR_DANG_MUL_2160; // R14
            default:        scale = `IODR_DANG_MUL_360;
        endcase
    end

    assign sync_edge = s_q.sync_sync & ~s_q.sync_prev;
    assign scaled    = sync_mode == `IODR_SYNC_SCALED;
    // >= so a lowered setting mid-period still ends the period
    assign update    = sample_strobe && !reset_cmd && s_q.dec_cnt >= decimation_setting; // R10

    genvar ax;
    generate
        for (ax = 0; ax < 3; ax++)
        begin : g_axis
            iodr_integ u_integ (
                .ref_clk (ref_clk),
                .arst_n  (arst_n),
                .sample  (sample_strobe && !reset_cmd),
                .last    (update),
                .clear   (reset_cmd),
                .rate    (rate_in[ax]),
                .scale   (scale),
                .dang    (dang[ax])
            );
        end
    endgenerate

    always_comb
    begin
        case ({rd_addr[`IODR_ADDR_W-1:1], 1'b0})
            `IODR_OFF_ACCX_LO:  mux = s_q.accel[0][15:0]; // R2
            `IODR_OFF_ACCX_HI:  mux = s_q.accel[0][31:16]; // R1
            `IODR_OFF_ACCY_LO:  mux = s_q.accel[1][15:0];
            `IODR_OFF_ACCY_HI:  mux = s_q.accel[1][31:16];
            `IODR_OFF_ACCZ_LO:  mux = s_q.accel[2][15:0];
            `IODR_OFF_ACCZ_HI:  mux = s_q.accel[2][31:16];
            `IODR_OFF_TEMP:     mux = s_q.temp; // R3
            `IODR_OFF_STAMP:    mux = s_q.stamp; // R4
            `IODR_OFF_COUNT:    mux = s_q.count;
            `IODR_OFF_DANGX_LO: mux = dang[0][15:0]; // R13
            `IODR_OFF_DANGX_HI: mux = dang[0][31:16]; // R15
            `IODR_OFF_DANGY_LO: mux = dang[1][15:0];
            `IODR_OFF_DANGY_HI: mux = dang[1][31:16];
            `IODR_OFF_DANGZ_LO: mux = dang[2][15:0];
            `IODR_OFF_DANGZ_HI: mux = dang[2][31:16];
            default:            mux = `IODR_WORD_ZERO;
        endcase
    end

    always_comb
    begin
        s_d           = s_q;
        s_d.sync_meta = sync_pin;
        s_d.sync_sync = s_q.sync_meta;
        s_d.sync_prev = s_q.sync_sync;

        // sync-relative time base
        if (!scaled || sync_edge)
        begin
            s_d.tick   = '0; // R4
            s_d.ts_run = `IODR_WORD_ZERO;
        end
        else if (s_q.tick == `IODR_TICK_W'(TS_CYCLES - 1))
        begin
            s_d.tick   = '0;
            s_d.ts_run = s_q.ts_run + `IODR_WORD_ONE; // R4
        end
        else
        begin
            s_d.tick = s_q.tick + `IODR_TICK_W'(1);
        end

        // all words of one update load in the same cycle
        if (reset_cmd)
        begin
            s_d.dec_cnt = `IODR_WORD_ZERO;
            s_d.count   = `IODR_WORD_ZERO; // R7
        end
        else if (update)
        begin
            s_d.dec_cnt = `IODR_WORD_ZERO;
            s_d.accel   = accel_in; // R16
            s_d.temp    = temp_in; // R3
            s_d.stamp   = s_q.ts_run; // R6
            s_d.count   = s_q.count + `IODR_WORD_ONE; // R8
        end
        else if (sample_strobe)
        begin
            s_d.dec_cnt = s_q.dec_cnt + `IODR_WORD_ONE;
        end

        // a stale stamp outside scaled mode would mislead the host
        if (!scaled)
            s_d.stamp = `IODR_WORD_ZERO; // R5

        s_d.rd_ack  = rd_req;
        s_d.rd_data = rd_req ? mux : s_q.rd_data;
        s_d.ready   = update;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign rd_data           = s_q.rd_data;
    assign rd_ack            = s_q.rd_ack;
    assign data_ready_output = s_q.ready;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_count_inc;
        update |=> s_q.count == iodr_word_t'($past(s_q.count) + `IODR_WORD_ONE);
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("counter did not step by one"); // R8

    property p_count_clear;
        reset_cmd |=> s_q.count == `IODR_WORD_ZERO;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("counter not cleared by reset command"); // R7

    property p_count_hold;
        !update && !reset_cmd |=> $stable(s_q.count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved without update"); // R8

    property p_stamp_mode;
        !scaled |=> s_q.stamp == `IODR_WORD_ZERO || $past(scaled, 1) != scaled;
    endproperty
    a_stamp_mode: assert property (p_stamp_mode) else $error("stamp nonzero outside scaled mode"); // R5

    property p_stamp_load;
        update && scaled |=> s_q.stamp == $past(s_q.ts_run);
    endproperty
    a_stamp_load: assert property (p_stamp_load) else $error("stamp not loaded from time base"); // R6

    property p_sync_restart;
        scaled && sync_edge |=> s_q.ts_run == `IODR_WORD_ZERO ##1 s_q.ts_run == `IODR_WORD_ZERO;
    endproperty
    a_sync_restart: assert property (p_sync_restart) else $error("time base not restarted by sync"); // R4

    property p_ts_step;
        scaled && !sync_edge && s_q.ts_run != $past(s_q.ts_run) && $past(scaled) && s_q.ts_run != 0
            |-> $past(s_q.tick) == `IODR_TICK_W'(TS_CYCLES - 1);
    endproperty
    a_ts_step: assert property (p_ts_step) else $error("time base stepped off its period"); // R4

    property p_accel_pair;
        update |=> s_q.accel[0] == $past(accel_in[0]) && s_q.temp == $past(temp_in);
    endproperty
    a_accel_pair: assert property (p_accel_pair) else $error("accel or temp not loaded together"); // R16

    property p_count_read;
        rd_req && rd_addr == `IODR_OFF_COUNT |=> rd_ack && rd_data == $past(s_q.count);
    endproperty
    a_count_read: assert property (p_count_read) else $error("counter read returned wrong word"); // R8

    property p_dr_pulse;
        update |=> data_ready_output ##1 !data_ready_output || $past(update);
    endproperty
    a_dr_pulse: assert property (p_dr_pulse) else $error("data ready not a pulse per update"); // R10

    property p_dr_idle;
        !update |=> !data_ready_output;
    endproperty
    a_dr_idle: assert property (p_dr_idle) else $error("data ready without update"); // R8

    property p_accx_lo_read;
        rd_req && rd_addr == `IODR_OFF_ACCX_LO |=> rd_data == $past(s_q.accel[0][15:0]);
    endproperty
    a_accx_lo_read: assert property (p_accx_lo_read) else $error("accel x low word read wrong"); // R2

    property p_accy_lo_read;
        rd_req && rd_addr == `IODR_OFF_ACCY_LO |=> rd_data == $past(s_q.accel[1][15:0]);
    endproperty
    a_accy_lo_read: assert property (p_accy_lo_read) else $error("accel y low word read wrong"); // R2

    property p_accx_hi_read;
        rd_req && rd_addr == `IODR_OFF_ACCX_HI |=> rd_data == $past(s_q.accel[0][31:16]);
    endproperty
    a_accx_hi_read: assert property (p_accx_hi_read) else $error("accel x high word read wrong"); // R1

    property p_accz_hi_read;
        rd_req && rd_addr == `IODR_OFF_ACCZ_HI |=> rd_data == $past(s_q.accel[2][31:16]);
    endproperty
    a_accz_hi_read: assert property (p_accz_hi_read) else $error("accel z high word read wrong"); // R1

    property p_temp_read;
        rd_req && rd_addr == `IODR_OFF_TEMP |=> rd_data == $past(s_q.temp);
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature read wrong"); // R3

    property p_stamp_read;
        rd_req && rd_addr == `IODR_OFF_STAMP |=> rd_data == $past(s_q.stamp);
    endproperty
    a_stamp_read: assert property (p_stamp_read) else $error("stamp read wrong"); // R4

    property p_dangx_lo_read;
        rd_req && rd_addr == `IODR_OFF_DANGX_LO |=> rd_data == $past(dang[0][15:0]);
    endproperty
    a_dangx_lo_read: assert property (p_dangx_lo_read) else $error("delta angle x low word read wrong"); // R13

    property p_dangx_hi_read;
        rd_req && rd_addr == `IODR_OFF_DANGX_HI |=> rd_data == $past(dang[0][31:16]);
    endproperty
    a_dangx_hi_read: assert property (p_dangx_hi_read) else $error("delta angle x high word read wrong"); // R15

    property p_dangz_hi_read;
        rd_req && rd_addr == `IODR_OFF_DANGZ_HI |=> rd_data == $past(dang[2][31:16]);
    endproperty
    a_dangz_hi_read: assert property (p_dangz_hi_read) else $error("delta angle z high word read wrong"); // R15

    property p_read_hold;
        !rd_req |=> !rd_ack && $stable(rd_data);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read port moved without request"); // R16

    property p_dec_restart;
        update |=> s_q.dec_cnt == `IODR_WORD_ZERO;
    endproperty
    a_dec_restart: assert property (p_dec_restart) else $error("decimation count not restarted"); // R10

    property p_dec_step;
        sample_strobe && !reset_cmd && !update |=> s_q.dec_cnt == iodr_word_t'($past(s_q.dec_cnt) + `IODR_WORD_ONE);
    endproperty
    a_dec_step: assert property (p_dec_step) else $error("decimation count did not step"); // R10

    property p_ts_idle;
        !scaled |=> s_q.ts_run == `IODR_WORD_ZERO;
    endproperty
    a_ts_idle: assert property (p_ts_idle) else $error("time base ran outside scaled mode"); // R5

    property p_axes_pair;
        update |=> s_q.accel[1] == $past(accel_in[1]) && s_q.accel[2] == $past(accel_in[2]);
    endproperty
    a_axes_pair: assert property (p_axes_pair) else $error("accel y or z not loaded together"); // R16
endmodule

// ===== sim/iodr_host.sv
// host model reading the output words over the word read port
// assumes: requests change at the falling edge of ref_clk
`include "iodr_params.svh"
module iodr_host
    import iodr_pkg::*;
(
    // clock
    input  wire logic               ref_clk,
    // register read port
    output logic                    rd_req,
    output logic [`IODR_ADDR_W-1:0] rd_addr,
    input  wire iodr_word_t         rd_data,
    input  wire logic               rd_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        rd_req = 1'b0;
        rd_addr = 7'h55;
    end

    // host-side correction by the measured ready rate
    function automatic longint rescale(input longint dang, input longint ready_hz);
        return dang * 2000 / ready_hz;
    endfunction

    // random idle gaps make the host prompt or slow
    task automatic read(input logic [6:0] a, output iodr_word_t d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        repeat ($urandom_range(0, 2)) @(negedge ref_clk);
        @(negedge ref_clk);
        rd_req = 1'b1;
        rd_addr = a;
        // one-cycle strobe; the registered answer stands at the next falling edge
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(negedge ref_clk);
            if (rd_ack === 1'b1)
            begin
                ok = 1'b1;
                d = rd_data;
            end
            rd_req = 1'b0;
        end
        // released address toggles so a stale one cannot pass
        rd_addr = ~a;
    endtask
endmodule

// ===== sim/iodr_top_test.sv
// self-checking bench: bench model of the output words against iodr_top
// assumes: iodr_pkg and iodr_host compiled first
`include "iodr_params.svh"
module iodr_top_test
    import iodr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               ref_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               sample_strobe = 1'b0;
    iodr_sample_t [2:0] accel_in = '0;
    iodr_sample_t [2:0] rate_in = '0;
    iodr_word_t         temp_in = '0;
    logic [2:0]         sync_mode = 3'h0;
    iodr_word_t         decimation_setting = '0;
    logic [1:0]         variant = 2'h0;
    logic               reset_cmd = 1'b0;
    logic               sync_pin = 1'b0;
    logic               rd_req;
    logic [6:0]         rd_addr;
    iodr_word_t         rd_data;
    logic               rd_ack;
    logic               data_ready_output;
    int                 fail_count = 0;
    int                 comparisons = 0;
    longint             m_prev[3] = '{default: 0};
    longint             m_sum[3] = '{default: 0};
    logic [31:0]        m_acc[3] = '{default: 32'h0};
    logic [31:0]        m_dang[3] = '{default: 32'h0};
    logic [15:0]        m_temp = 16'h0000;
    logic [15:0]        m_cnt = 16'h0000;
    int                 m_k = 0;
    logic               m_upd = 1'b0;

    iodr_top #(.TS_CYCLES(4)) iodr_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .sample_strobe(sample_strobe),
        .accel_in(accel_in), .rate_in(rate_in), .temp_in(temp_in), .sync_mode(sync_mode),
        .decimation_setting(decimation_setting), .variant(variant), .reset_cmd(reset_cmd), .sync_pin(sync_pin),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack),
        .data_ready_output(data_ready_output));
    iodr_host iodr_host_inst (.ref_clk(ref_clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_ack(rd_ack));

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_range(input iodr_word_t got, input int lo, input int hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            fail_count++;
            $display("Error at %0t: stamp %h outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // stamp expected 0 here: checks run outside scaled sync mode
    function automatic logic [15:0] exp_word(input int a);
        case (a)
            7'h10, 7'h14, 7'h18: return m_acc[(a - 7'h10) / 4][15:0];
            7'h12, 7'h16, 7'h1a: return m_acc[(a - 7'h12) / 4][31:16];
            7'h1c: return m_temp;
            7'h22: return m_cnt;
            7'h24, 7'h28, 7'h2c: return m_dang[(a - 7'h24) / 4][15:0];
            7'h26, 7'h2a, 7'h2e: return m_dang[(a - 7'h26) / 4][31:16];
            default: return 16'h0000;
        endcase
    endfunction

    task automatic check_all();
        iodr_word_t d;
        logic ok;
        for (int a = 0; a < 7'h32; a += 2)
        begin
            iodr_host_inst.read(7'(a), d, ok);
            cmp({31'h0, ok}, 32'h1, "read ack");
            cmp({16'h0, d}, {16'h0, exp_word(a)}, "read word");
        end
    endtask

    // the sum is scaled once per period, with the variant at the update
    task automatic model_step();
        longint mul;
        mul = (variant == 2'h1) ? `IODR_DANG_MUL_720 : ((variant == 2'h2) ? `IODR_DANG_MUL_2160 : `IODR_DANG_MUL_360);
        m_upd = 1'b0;
        if (reset_cmd)
        begin
            m_cnt = 16'h0000;
            m_k = 0;
            m_prev = '{default: 0};
            m_sum = '{default: 0};
            return;
        end
        for (int i = 0; i < 3; i++)
        begin
            m_sum[i] += longint'(signed'(rate_in[i])) + m_prev[i];
            m_prev[i] = longint'(signed'(rate_in[i]));
        end
        if (m_k < int'(decimation_setting))
        begin
            m_k++;
            return;
        end
        m_k = 0;
        m_upd = 1'b1;
        m_cnt++;
        m_temp = temp_in;
        for (int i = 0; i < 3; i++)
        begin
            m_acc[i] = accel_in[i];
            m_dang[i] = 32'((m_sum[i] * mul) >>> 16);
            m_sum[i] = 0;
        end
    endtask

    task automatic do_sample(input logic rc);
        @(negedge ref_clk);
        for (int i = 0; i < 3; i++)
        begin
            accel_in[i] = $urandom;
            rate_in[i] = 32'(signed'($urandom) >>> 12);
        end
        temp_in = 16'($urandom);
        reset_cmd = rc;
        sample_strobe = 1'b1;
        model_step();
        @(negedge ref_clk);
        sample_strobe = 1'b0;
        reset_cmd = 1'b0;
        cmp({31'h0, data_ready_output}, {31'h0, m_upd}, "update marker");
    endtask

    initial
    begin
        #400000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        iodr_word_t d;
        logic ok;
        void'($urandom(83622));
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        check_all();
        $display("test reset done");
        for (int v = 0; v < 4; v++)
        begin
            @(negedge ref_clk);
            variant = 2'(v);
            decimation_setting = 16'(v);
            do_sample(1'b1);
            repeat (2 * v + 3) do_sample(1'b0);
            check_all();
        end
        $display("test integration done");
        @(negedge ref_clk);
        decimation_setting = 16'h0000;
        sync_mode = `IODR_SYNC_SCALED;
        sync_pin = 1'b1;
        repeat (39) @(negedge ref_clk);
        do_sample(1'b0);
        iodr_host_inst.read(7'h1e, d, ok);
        cmp_range(d, 8, 10);
        @(negedge ref_clk);
        sync_pin = 1'b0;
        sync_mode = 3'h0;
        do_sample(1'b0);
        check_all();
        $display("test stamp done");
        // back-to-back updates walk the counter once round
        @(negedge ref_clk);
        sample_strobe = 1'b1;
        for (int n = 0; n < 65536; n++)
        begin
            model_step();
            @(negedge ref_clk);
        end
        sample_strobe = 1'b0;
        check_all();
        $display("test wrap done");
        report_and_stop();
    end
endmodule
